// >>> hdl/host_port_pkg.sv
// Purpose: Shared constants and carriers for the asynchronous host port
// Assumes: One core clock, strobes sampled synchronous after two-stage sync
// Notes:   Bus width mode is a top-level input, not a register
package host_port_pkg;

  // ----------------------------------------------------------------
  // Widths and codes
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LANES       = 4;
  localparam logic [6:0]  BASE_ADDR   = 7'h00;
  localparam logic [6:0]  BASE_MASK   = 7'h00; // Set bits are compared
  localparam logic [1:0]  BUS_8       = 2'h0;
  localparam logic [1:0]  BUS_16      = 2'h1;
  localparam logic [1:0]  BUS_32      = 2'h2;
  localparam logic [3:0]  SEL_WORD    = 4'h0;
  localparam logic [3:0]  SEL_LOW16   = 4'hC;
  localparam logic [3:0]  SEL_HIGH16  = 4'h3;
  localparam logic [3:0]  SEL_B0      = 4'hE;
  localparam logic [3:0]  SEL_B1      = 4'hD;
  localparam logic [3:0]  SEL_B2      = 4'hB;
  localparam logic [3:0]  SEL_B3      = 4'h7;
  localparam logic [3:0]  LANES_NONE  = 4'h0;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
  // Core cycles the sequencer spends in hold per access
  localparam int unsigned WAIT_CYCLES = 2;
  localparam logic [1:0]  WAIT_LAST   = 2'(WAIT_CYCLES - 1);

  // Internal access request toward the core
  typedef struct packed {
    logic        write;
    logic [6:0]  addr;
    logic [3:0]  lanes;
    logic [31:0] data;
  } core_req_t;

  typedef enum logic [1:0] {IDLE, HOLD, DONE} acc_state_t;

endpackage

// >>> hdl/host_port_unit.sv
// Purpose: SRAM-like asynchronous slave host port with lane steering
// Assumes: Core read data is steady while an access is held
// Notes:   Wait output drops on strobe fall, rises when core is done;
//          strobes pass two sync stages, so every access costs
//          at least six core cycles

// How it works
// - Decode address only when qualifier low
// - Lane selects encode word, halves, bytes
// - Wait output low requests host wait states
// - Bus width mode sets legal transfer sizes
// - 32-bit bus takes byte, half, word
// - 16-bit bus refuses full-word transfers
// - 8-bit bus allows byte transfers only
// - Internal swapping reaches every lane on 16-bit bus, lanes 0 and 1 only on 8-bit
// - 8-bit host uses only data bits 7..0
// - 16-bit host uses bits 15..0 only
// - Port has address, data, strobes, selects, ready, irq
// - Slave needs no external latch or glue
// - Selected output is combinational decode
// - Write data taken at edge 3, after the write strobe fall has passed both sync stages
// - Wait asserted at fall of active strobe
// - 8-bit mode odd address selects lane 1
module host_port_unit (
  // Clock and reset
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  // Host bus
  input  wire logic [host_port_pkg::ADDR_W-1:0] HOST_ADDR,
  input  wire logic                        ADDR_QUALIFIER_N,
  input  wire logic                        READ_STROBE_N,
  input  wire logic                        WRITE_STROBE_N,
  input  wire logic [3:0]                  BYTE_LANE_SEL_N,
  input  wire logic [host_port_pkg::DATA_W-1:0] CPU_SIDE_DATA_IN,
  output logic [host_port_pkg::DATA_W-1:0] CPU_SIDE_DATA_OUT,
  output logic                             CPU_SIDE_DATA_OE_N,
  output logic                             WAIT_READY_N,
  output logic                             HOST_IRQ_N,
  output logic                             DEVICE_SELECTED_N,
  // Configuration
  input  wire logic [1:0]                  BUS_MODE,
  // Core side
  output host_port_pkg::core_req_t         CORE_REQ,
  output logic                             CORE_REQ_VALID,
  input  wire logic [host_port_pkg::DATA_W-1:0] CORE_RDATA,
  input  wire logic                        CORE_IRQ
);
  import host_port_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Decode and lanes
  logic        selected;
  logic [3:0]  lanes;
  logic        size_ok;

  // Strobe synchronisers and edges
  logic [1:0]  rd_sync;
  logic [1:0]  wr_sync;
  logic        rd_prev;
  logic        wr_prev;
  logic        rd_fall;
  logic        wr_fall;
  logic        strobe_rise;

  // Sequencer
  acc_state_t  state;
  logic        take;
  logic        last;
  logic [1:0]  wait_cnt;

  // Data paths
  logic [31:0] wr_steer;
  logic [31:0] rd_steer;
  logic [31:0] rd_hold;
  logic [3:0]  rd_lanes;
  logic [7:0]  core_byte [LANES];

  // Pure decode, no latch needed on the address
  assign selected          = !ADDR_QUALIFIER_N &&
                             ((HOST_ADDR & BASE_MASK) == BASE_ADDR);
  assign DEVICE_SELECTED_N = !selected;

  // Lane selects to active-high lanes, 8-bit mode derives lane from A0
  always_comb begin
    lanes = ~BYTE_LANE_SEL_N;
    if (BUS_MODE == BUS_8) begin
      lanes = HOST_ADDR[0] ? 4'h2 : 4'h1;
    end
  end

  // Legal sizes per physical width; wrong encodings are dropped
  always_comb begin
    size_ok = 1'b0;
    case (BUS_MODE)
      BUS_32:  size_ok = (BYTE_LANE_SEL_N == SEL_WORD)   ||
                         (BYTE_LANE_SEL_N == SEL_LOW16)  ||
                         (BYTE_LANE_SEL_N == SEL_HIGH16) ||
                         (BYTE_LANE_SEL_N == SEL_B0)     ||
                         (BYTE_LANE_SEL_N == SEL_B1)     ||
                         (BYTE_LANE_SEL_N == SEL_B2)     ||
                         (BYTE_LANE_SEL_N == SEL_B3);
      BUS_16:  size_ok = (BYTE_LANE_SEL_N == SEL_LOW16)  ||
                         (BYTE_LANE_SEL_N == SEL_HIGH16) ||
                         (BYTE_LANE_SEL_N == SEL_B0)     ||
                         (BYTE_LANE_SEL_N == SEL_B1)     ||
                         (BYTE_LANE_SEL_N == SEL_B2)     ||
                         (BYTE_LANE_SEL_N == SEL_B3);
      BUS_8:   size_ok = 1'b1;
      default: size_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Steering
  // ----------------------------------------------------------------
  // Narrow hosts present data on low lanes; move it to the chosen lane
  always_comb begin
    wr_steer = CPU_SIDE_DATA_IN;
    case (BUS_MODE)
      BUS_8:   wr_steer = {4{CPU_SIDE_DATA_IN[7:0]}};
      BUS_16:  wr_steer = {2{CPU_SIDE_DATA_IN[15:0]}};
      default: wr_steer = CPU_SIDE_DATA_IN;
    endcase
  end

  // Byte view of the core word, one entry per lane
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign core_byte[i] = CORE_RDATA[8*i +: 8];
  end

  // Read data from the chosen lane folded onto the host's lanes
  always_comb begin
    rd_steer = CORE_RDATA;
    case (BUS_MODE)
      BUS_8: begin
        rd_steer = {24'h00_0000, core_byte[0]};
        if (rd_lanes[1]) rd_steer = {24'h00_0000, core_byte[1]};
        if (rd_lanes[2]) rd_steer = {24'h00_0000, core_byte[2]};
        if (rd_lanes[3]) rd_steer = {24'h00_0000, core_byte[3]};
      end
      BUS_16: begin
        rd_steer = {16'h0000, CORE_RDATA[15:0]};
        if (rd_lanes[3:2] != 2'h0) rd_steer = {16'h0000, CORE_RDATA[31:16]};
      end
      default: rd_steer = CORE_RDATA;
    endcase
  end

  // ----------------------------------------------------------------
  // Strobe synchronisers
  // ----------------------------------------------------------------
  // Two stages; edges are taken from the second stage only
  // Read strobe; reset to the idle high level so no false fall
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_sync <= 2'h3;
      rd_prev <= 1'b1;
    end else begin
      rd_sync <= {rd_sync[0], READ_STROBE_N};
      rd_prev <= rd_sync[1];
    end
  end

  // Write strobe, same two stages as the read side
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_sync <= 2'h3;
      wr_prev <= 1'b1;
    end else begin
      wr_sync <= {wr_sync[0], WRITE_STROBE_N};
      wr_prev <= wr_sync[1];
    end
  end

  assign rd_fall     = rd_prev && !rd_sync[1];
  assign wr_fall     = wr_prev && !wr_sync[1];
  assign strobe_rise = rd_sync[1] && wr_sync[1];

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // One request per strobe; the core answers after WAIT_CYCLES
  assign take = (rd_fall || wr_fall) && selected && size_ok && (state == IDLE);
  assign last = (state == HOLD) && (wait_cnt == WAIT_LAST);

  // State register; only idle takes a new strobe
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= IDLE;
    end else begin
      case (state)
        IDLE: begin
          if (take) begin
            state <= HOLD;
          end
        end
        HOLD: begin
          if (last) begin
            state <= DONE;
          end
        end
        DONE: begin
          // Both synced strobes high, so a slow release is not a new access
          if (strobe_rise) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Wait counter, restarted by each accepted request
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_cnt <= 2'h0;
    end else if (take) begin
      wait_cnt <= 2'h0;
    end else if (state == HOLD) begin
      wait_cnt <= wait_cnt + 2'h1;
    end
  end

  // Request fields captured at the detect edge; host holds them steady
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_REQ <= '0;
    end else if (take) begin
      CORE_REQ.write <= wr_fall;
      CORE_REQ.addr  <= HOST_ADDR;
      CORE_REQ.lanes <= lanes;
      CORE_REQ.data  <= wr_steer;
    end
  end

  // One-cycle request pulse toward the core
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CORE_REQ_VALID <= 1'b0;
    end else begin
      CORE_REQ_VALID <= take;
    end
  end

  // Lanes of the running access, kept for read folding
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_lanes <= LANES_NONE;
    end else if (take) begin
      rd_lanes <= lanes;
    end
  end

  // Hold read data stable until the host's strobe rises
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_hold <= DATA_RESET;
    end else if (last) begin
      rd_hold <= rd_steer;
    end
  end

  // ----------------------------------------------------------------
  // Access timing, in core clock edges after the strobe falls
  // ----------------------------------------------------------------
  // Edge 1 and 2: the strobe walks through the two sync stages
  // Edge 3: fall detected; address, lanes and write data captured
  // Edge 4: the core samples the one-cycle request pulse
  // Edge 5: read word folded and latched, state moves to done
  // After edge 5 the wait output rises; the host may then raise
  // its strobe and take read data on that rise
  // Two more edges pass before the synced strobes read high, and a
  // third returns the port to idle; a strobe that falls again inside
  // that gap is not waited on, so hosts must space accesses
  // Address, qualifier and selects are sampled at edge 3 only,
  // so they must stay steady from the strobe fall until then
  // A refused access (bad size or mode) never reaches done: wait
  // stays low for as long as the strobe is held, and only the
  // host's own timeout ends it

  // ----------------------------------------------------------------
  // Host-facing outputs
  // ----------------------------------------------------------------
  // Wait drops combinationally at strobe fall so slow sync is covered
  assign WAIT_READY_N = !(selected && (state != DONE) &&
                          (!READ_STROBE_N || !WRITE_STROBE_N));

  // Bus driven only during a selected read; enable is active low
  assign CPU_SIDE_DATA_OE_N = !(selected && !READ_STROBE_N);
  assign CPU_SIDE_DATA_OUT  = rd_hold;

  // Registered interrupt level from the core
  // One cycle of latency keeps core glitches off the pin
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      HOST_IRQ_N <= 1'b1;
    end else begin
      HOST_IRQ_N <= !CORE_IRQ;
    end
  end

endmodule

// >>> tb/host_bus_model.sv
// Purpose: Host processor on the async bus
// Assumes: Moves 1 ns after a clock edge
// Notes:   Released data shows a changing pattern
module host_bus_model (
  // Device answers
  input wire logic        CLK,
  input wire logic        WAIT_READY_N,
  input wire logic        OE_N,
  input wire logic [31:0] DOUT,
  // Host bus
  output logic [6:0]      ADDR,
  output logic            QUAL_N,
  output logic            RD_N,
  output logic            WR_N,
  output logic [3:0]      SEL_N,
  output logic [31:0]     DWIRE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] drv = 32'h0;
  logic        hold = 1'b0;
  initial {ADDR, QUAL_N, RD_N, WR_N, SEL_N} = {7'h00, 3'h7, 4'hF};
  // Shared wire; idle host value flips so stale data never matches
  assign DWIRE = OE_N ? drv : DOUT;
  always @(posedge CLK) if (!hold) drv <= ~drv;
  // One access, strobe held until wait ends, bounded
  task automatic access(input logic wr, qn, input logic [6:0] a, input logic [3:0] be,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
    @(posedge CLK) #1;
    {ADDR, QUAL_N, SEL_N, hold} = {a, qn, be, wr};
    if (wr) drv = d;
    {RD_N, WR_N} = {wr, !wr};
    ok = 1'b0;
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge CLK);
      ok = WAIT_READY_N;
    end
    q = DWIRE;
    #1 {RD_N, WR_N, QUAL_N, hold} = 4'hE;
    repeat (5) @(posedge CLK);
  endtask
endmodule

// >>> tb/host_port_unit_checker.sv
// Purpose: Pin-level checks on the host port
// Assumes: Whole address space selects
// Notes:   Sees only top-level ports
module host_port_unit_checker import host_port_pkg::*; (
  // Clock, reset
  input wire logic      CLK,
  input wire logic      ARST_N,
  // Host side
  input wire logic      ADDR_QUALIFIER_N,
  input wire logic      READ_STROBE_N,
  input wire logic      WRITE_STROBE_N,
  input wire logic [1:0] BUS_MODE,
  input wire logic      CPU_SIDE_DATA_OE_N,
  input wire logic      WAIT_READY_N,
  input wire logic      HOST_IRQ_N,
  input wire logic      DEVICE_SELECTED_N,
  // Core side
  input wire core_req_t CORE_REQ,
  input wire logic      CORE_REQ_VALID,
  input wire logic      CORE_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // Checks
  // ------
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  wire logic strb_n = READ_STROBE_N & WRITE_STROBE_N;
  sel_decode_a: assert property (DEVICE_SELECTED_N == ADDR_QUALIFIER_N)
    else $error("select decode wrong");
  drive_gate_a: assert property (CPU_SIDE_DATA_OE_N == (DEVICE_SELECTED_N | READ_STROBE_N))
    else $error("data drive gate wrong");
  wait_fall_a: assert property ($fell(strb_n) && !DEVICE_SELECTED_N |-> !WAIT_READY_N)
    else $error("no wait on strobe fall");
  sync_lag_a: assert property ($fell(strb_n) && !DEVICE_SELECTED_N && BUS_MODE == BUS_32
    |-> !CORE_REQ_VALID [*3] ##[1:3] CORE_REQ_VALID) else $error("request timing wrong");
  wait_end_a: assert property (CORE_REQ_VALID |-> ##[1:5] $rose(WAIT_READY_N))
    else $error("wait not released");
  valid_pulse_a: assert property (CORE_REQ_VALID |=> !CORE_REQ_VALID)
    else $error("request not a pulse");
  half_only_a: assert property (CORE_REQ_VALID && BUS_MODE == BUS_16 |-> CORE_REQ.lanes != 4'hF)
    else $error("word taken on half bus");
  byte_only_a: assert property (CORE_REQ_VALID && BUS_MODE == BUS_8
    |-> CORE_REQ.lanes inside {4'h1, 4'h2}) else $error("wide access on byte bus");
  bad_mode_a: assert property (BUS_MODE == 2'h3 |-> !CORE_REQ_VALID)
    else $error("request in bad mode");
  irq_follow_a: assert property (HOST_IRQ_N == !$past(CORE_IRQ))
    else $error("irq not following");
  cover property (CORE_REQ_VALID && CORE_REQ.write);
  cover property (CORE_REQ_VALID && !CORE_REQ.write);
  cover property (!HOST_IRQ_N);
endmodule

bind host_port_unit host_port_unit_checker host_port_unit_checker_inst (.*);

// >>> tb/test_async_host_bus_interface.sv
// Purpose: Random and corner accesses on the host port
// Assumes: Whole address space selects
// Notes:   Expectations from lane and shift rules
module test_async_host_bus_interface import host_port_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, core_irq, qual_n, rd_n, wr_n, oe_n, wait_n, irq_n, dsel_n, req_v, ok;
  logic [1:0] bus_mode;
  logic [3:0] sel_n;
  logic [6:0] addr;
  logic [31:0] dwire, dout, core_rdata;
  core_req_t req, got;
  int nreq = 0, mismatches = 0, checks_done = 0;
  logic [3:0] sels [7] = '{SEL_WORD, SEL_LOW16, SEL_HIGH16, SEL_B0, SEL_B1, SEL_B2, SEL_B3};
  host_port_unit host_port_unit_inst (.CLK(clk), .ARST_N(arst_n), .HOST_ADDR(addr),
    .ADDR_QUALIFIER_N(qual_n), .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
    .BYTE_LANE_SEL_N(sel_n), .CPU_SIDE_DATA_IN(dwire), .CPU_SIDE_DATA_OUT(dout),
    .CPU_SIDE_DATA_OE_N(oe_n), .WAIT_READY_N(wait_n), .HOST_IRQ_N(irq_n),
    .DEVICE_SELECTED_N(dsel_n), .BUS_MODE(bus_mode), .CORE_REQ(req),
    .CORE_REQ_VALID(req_v), .CORE_RDATA(core_rdata), .CORE_IRQ(core_irq));
  host_bus_model host_bus_model_inst (.CLK(clk), .WAIT_READY_N(wait_n), .OE_N(oe_n),
    .DOUT(dout), .ADDR(addr), .QUAL_N(qual_n), .RD_N(rd_n), .WR_N(wr_n), .SEL_N(sel_n),
    .DWIRE(dwire));
  always @(posedge clk) if (req_v) begin got <= req; nreq <= nreq + 1; end
  task automatic check(input logic good, input string m);
    checks_done++;
    if (good !== 1'b1) begin mismatches++; $display("CHECK FAILED %0t %s", $time, m); end
  endtask
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Internal lanes and host-side shift per bus mode
  function automatic logic [3:0] lanes_of(logic [1:0] m, logic a0, logic [3:0] s);
    return (m == BUS_8) ? (a0 ? 4'h2 : 4'h1) : ~s;
  endfunction
  function automatic int shift_of(logic [1:0] m, logic a0, logic [3:0] s);
    return (m == BUS_8) ? (a0 ? 8 : 0) : (m == BUS_16 && s[1:0] == 2'h3) ? 16 : 0;
  endfunction
  task automatic run(input logic [1:0] m, input logic wr, input logic [3:0] s,
                     input logic qn, good);
    logic [6:0] a;
    logic [31:0] d, q, k;
    logic [3:0] ln;
    int n0, sh;
    @(posedge clk) #1;
    {a, d, core_rdata, bus_mode, n0} = {7'($urandom), $urandom, $urandom, m, nreq};
    ln = lanes_of(m, a[0], s);
    k = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    sh = shift_of(m, a[0], s);
    host_bus_model_inst.access(wr, qn, a, s, d, q, ok);
    check(ok === (good | qn) && nreq == n0 + good, "request count");
    if (good) check(got.write === wr && got.addr === a, "request fields");
    if (good && wr) check(got.lanes === ln, "write lanes");
    if (good && wr) check((got.data & k) === ((d << sh) & k), "write steer");
    if (good && !wr) check((q & (k >> sh)) === ((core_rdata & k) >> sh), "read fold");
  endtask
  initial begin clk = 1'b0; forever #5 clk = ~clk; end
  initial begin repeat (20000) @(posedge clk); check(1'b0, "timeout"); end_of_test; end
  initial begin
    {arst_n, core_irq, bus_mode, core_rdata} = {2'h0, BUS_32, 32'h0};
    void'($urandom(29));
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    foreach (sels[j]) run(BUS_32, 1'(j % 2), sels[j], 1'b0, 1'b1);
    for (int i = 0; i < 60; i++)
      run(2'(i % 2), 1'($urandom), i % 2 ? sels[1 + $urandom % 6] : 4'($urandom), 1'b0, 1'b1);
    run(BUS_16, 1'b0, SEL_WORD, 1'b0, 1'b0);
    run(BUS_16, 1'b1, SEL_WORD, 1'b0, 1'b0);
    run(2'h3, 1'b1, SEL_B0, 1'b0, 1'b0);
    run(BUS_32, 1'b0, SEL_WORD, 1'b1, 1'b0);
    #1 core_irq = 1'b1;
    repeat (2) @(posedge clk);
    check(irq_n === 1'b0, "irq raise");
    #1 core_irq = 1'b0;
    repeat (2) @(posedge clk);
    check(irq_n === 1'b1, "irq clear");
    end_of_test;
  end
endmodule
